/* File: rtl/hcs_clock_ctrl.sv */
// high-speed clock source control: trim, pin select, start/stop sequence
// What this block and its software do
// RULE_01 - 8-bit trim register: 5-bit code, upper bits read 0, reset 10H.
// RULE_02 - code 00000 gives about -4.88%, 10000 none, 11111 about +5.10%.
// RULE_03 - a higher code never gives a lower frequency, nor the reverse.
// RULE_04 - external select 0 and pin select 1 put the pins in crystal mode.
// RULE_05 - clearing the crystal stop bit starts the crystal oscillator.
// RULE_06 - software polls the stabilisation status before using the crystal.
// RULE_07 - software leaves the pin select bits alone while the crystal runs.
// RULE_08 - after reset both high-speed clock pins are port pins.
// RULE_09 - with no high-speed clock in use the pins are ordinary ports.
// RULE_10 - the clock comes from a resonator or from an external clock pin.
// RULE_11 - the stop instruction halts internal and high-speed clocks.
// RULE_12 - software may stop any source that is not the processor clock.
// RULE_13 - a new trim code acts at once, with no reset or restart.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module hcs_clock_ctrl (
   input wire logic clock_i,                  // system clock, 250 MHz
   input wire logic rst_i,                    // sync reset, high
   input wire logic [15:0] addr_i,            // register address
   input wire logic [7:0] wdata_i,            // write data
   input wire logic wr_i,                     // write strobe
   input wire logic rd_i,                     // read strobe
   output logic [7:0] rdata_o,                // read data, next cycle
   input wire logic stop_insn_i,              // stop instruction pulse
   input wire logic wake_i,                   // wake from stop pulse
   input wire logic cpu_hs_sel_i,             // cpu runs on hs clock
   input wire logic [1:0] port_dout_i,        // port data {ro,ri}
   input wire logic [1:0] port_oe_i,          // port enables {ro,ri}
   input wire logic [1:0] pin_i,              // pin levels {ro,ri}
   output hcs_pkg::hcs_pin_drv_t pins_o,      // pin drive
   output logic [1:0] port_din_o,             // port data in
   output logic ext_clk_o,                    // external clock sample
   output logic xtal_en_o,                    // crystal amplifier on
   output logic int_osc_run_o,                // internal oscillator on
   output logic hs_stable_o,                  // hs clock usable
   output logic [4:0] trim_code_o,            // trim to oscillator
   output logic signed [15:0] trim_corr_o     // typical correction
);
   logic [4:0] trim_q;
   logic ext_sel_q;
   logic osc_sel_q;
   logic xstop_q;
   logic istop_q;
   hcs_pkg::hcs_state_t state_q;
   logic [7:0] div_q;
   logic [7:0] stab_q;
   logic tick;
   logic hs_run;
   logic wr_trim;
   logic wr_pin;
   logic wr_osc;
   logic new_xstop;
   logic new_istop;
   hcs_pkg::hcs_pin_mode_t pin_mode;

   assign wr_trim = wr_i && (addr_i == hcs_pkg::TRIM_ADDR);
   assign wr_pin = wr_i && (addr_i == hcs_pkg::PINCTL_ADDR);
   assign wr_osc = wr_i && (addr_i == hcs_pkg::CLOCK_PIN_CONTROL_ADDR);
   assign new_xstop = wdata_i[hcs_pkg::OSC_XSTOP_BIT];
   assign new_istop = wdata_i[hcs_pkg::OSC_ISTOP_BIT];
   assign hs_run = (state_q == hcs_pkg::HCS_START)
      || (state_q == hcs_pkg::HCS_STABLE);
   assign tick = (div_q == hcs_pkg::STAB_DIV_LAST);

   always_comb
   begin
      if (!osc_sel_q)
      begin
         pin_mode = hcs_pkg::HCS_PIN_PORT; // RULE_08 RULE_09
      end
      else if (ext_sel_q)
      begin
         pin_mode = hcs_pkg::HCS_PIN_EXT; // RULE_10
      end
      else
      begin
         pin_mode = hcs_pkg::HCS_PIN_XTAL; // RULE_04
      end
   end

   // trim register
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         trim_q <= hcs_pkg::TRIM_RST; // RULE_01
      end
      else if (wr_trim)
      begin
         trim_q <= wdata_i[4:0]; // RULE_01 RULE_13
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         trim_code_o <= hcs_pkg::TRIM_RST;
      end
      else
      begin
         // follows the register with no restart of the oscillator
         trim_code_o <= trim_q; // RULE_13
      end
   end

   // pin selection; writes dropped while the clock runs, so a stray
   // write cannot yank the pins out from under a live resonator
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         osc_sel_q <= 1'b0; // RULE_08
         ext_sel_q <= 1'b0;
      end
      else if (wr_pin && !hs_run)
      begin
         osc_sel_q <= wdata_i[hcs_pkg::PIN_OSC_SEL_BIT]; // RULE_07
         ext_sel_q <= wdata_i[hcs_pkg::PIN_EXT_SEL_BIT];
      end
   end

   // stop bits; a source feeding the cpu refuses to be stopped
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         xstop_q <= hcs_pkg::XSTOP_RST;
      end
      else if (wr_osc && !(new_xstop && cpu_hs_sel_i))
      begin
         xstop_q <= new_xstop; // RULE_05 RULE_12
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         istop_q <= hcs_pkg::ISTOP_RST;
      end
      else if (wr_osc && !(new_istop && !cpu_hs_sel_i))
      begin
         istop_q <= new_istop; // RULE_12
      end
   end

   // stabilisation step divider
   always_ff @(posedge clock_i)
   begin
      if (rst_i || tick)
      begin
         div_q <= 8'h00;
      end
      else
      begin
         div_q <= div_q + 8'h01;
      end
   end

   // hs clock sequence
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         state_q <= hcs_pkg::HCS_OFF;
      end
      else if (stop_insn_i)
      begin
         state_q <= hcs_pkg::HCS_HALT; // RULE_11
      end
      else
      begin
         unique case (state_q)
            hcs_pkg::HCS_OFF:
            begin
               if (!xstop_q && osc_sel_q)
               begin
                  state_q <= hcs_pkg::HCS_START; // RULE_05
               end
            end
            hcs_pkg::HCS_START:
            begin
               if (xstop_q || !osc_sel_q)
               begin
                  state_q <= hcs_pkg::HCS_OFF;
               end
               else if (ext_sel_q || stab_q == hcs_pkg::STAB_TARGET)
               begin
                  state_q <= hcs_pkg::HCS_STABLE; // RULE_06
               end
            end
            hcs_pkg::HCS_STABLE:
            begin
               if (xstop_q || !osc_sel_q)
               begin
                  state_q <= hcs_pkg::HCS_OFF; // RULE_12
               end
            end
            hcs_pkg::HCS_HALT:
            begin
               if (wake_i)
               begin
                  // restart counts stabilisation afresh
                  state_q <= hcs_pkg::HCS_OFF;
               end
            end
         endcase
      end
   end

   // elapsed stabilisation steps, held once stable for software to see
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         stab_q <= 8'h00;
      end
      else if (state_q == hcs_pkg::HCS_OFF
         || state_q == hcs_pkg::HCS_HALT)
      begin
         stab_q <= 8'h00;
      end
      else if (state_q == hcs_pkg::HCS_START && tick
         && stab_q != hcs_pkg::STAB_TARGET)
      begin
         stab_q <= stab_q + 8'h01; // RULE_06
      end
   end

   // clock enables
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         xtal_en_o <= 1'b0;
         hs_stable_o <= 1'b0;
      end
      else
      begin
         xtal_en_o <= hs_run && !ext_sel_q; // RULE_05 RULE_11
         hs_stable_o <= (state_q == hcs_pkg::HCS_STABLE);
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         int_osc_run_o <= 1'b1;
      end
      else
      begin
         int_osc_run_o <= !istop_q
            && (state_q != hcs_pkg::HCS_HALT); // RULE_11 RULE_12
      end
   end

   // register read, one cycle later; unmapped reads as zero
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !rd_i)
      begin
         rdata_o <= 8'h00;
      end
      else
      begin
         unique case (addr_i)
            hcs_pkg::TRIM_ADDR:
               rdata_o <= {3'h0, trim_q}; // RULE_01
            hcs_pkg::PINCTL_ADDR:
               rdata_o <= {6'h00, ext_sel_q, osc_sel_q};
            hcs_pkg::CLOCK_PIN_CONTROL_ADDR:
               rdata_o <= {6'h00, istop_q, xstop_q};
            hcs_pkg::STAT_ADDR:
               rdata_o <= stab_q; // RULE_06
            default:
               rdata_o <= 8'h00;
         endcase
      end
   end

   hcs_trim_map u_trim_map (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .code_i(trim_q),
      .corr_o(trim_corr_o)
   );

   hcs_pin_mux u_pin_mux (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .mode_i(pin_mode),
      .ext_run_i(hs_run),
      .port_dout_i(port_dout_i),
      .port_oe_i(port_oe_i),
      .pin_i(pin_i),
      .pins_o(pins_o),
      .port_din_o(port_din_o),
      .ext_clk_o(ext_clk_o)
   );

   sequence s_trim_write;
      wr_trim;
   endsequence

   sequence s_xtal_start;
      wr_osc && !new_xstop && osc_sel_q && !ext_sel_q
         && state_q == hcs_pkg::HCS_OFF && !stop_insn_i;
   endsequence

   a_trim_reset: assert property (@(posedge clock_i)
      $fell(rst_i) |-> trim_q == hcs_pkg::TRIM_RST) // RULE_01
      else $error("trim reset value wrong");

   a_trim_upper_zero: assert property (@(posedge clock_i) disable iff (rst_i)
      rd_i && addr_i == hcs_pkg::TRIM_ADDR |=> rdata_o[7:5] == 3'h0
         && rdata_o[4:0] == $past(trim_q)) // RULE_01
      else $error("trim readback wrong");

   a_trim_takes_effect: assert property (@(posedge clock_i)
      disable iff (rst_i)
      s_trim_write |-> ##2 trim_code_o == $past(wdata_i[4:0], 2)) // RULE_13
      else $error("trim code not applied");

   a_trim_default_zero: assert property (@(posedge clock_i)
      disable iff (rst_i)
      trim_q == hcs_pkg::TRIM_RST ##1 trim_q == hcs_pkg::TRIM_RST
         |=> trim_corr_o == 16'sh0000) // RULE_02
      else $error("default trim not neutral");

   a_xtal_pins: assert property (@(posedge clock_i) disable iff (rst_i)
      osc_sel_q && !ext_sel_q |=> !pins_o.oe_ri && !pins_o.oe_ro) // RULE_04
      else $error("pins driven in crystal mode");

   a_xtal_start: assert property (@(posedge clock_i) disable iff (rst_i)
      s_xtal_start ##1 (!stop_insn_i && !xstop_q && osc_sel_q)
         |=> state_q == hcs_pkg::HCS_START ##1 xtal_en_o) // RULE_05
      else $error("crystal did not start");

   a_port_after_reset: assert property (@(posedge clock_i)
      $fell(rst_i) |-> pin_mode == hcs_pkg::HCS_PIN_PORT) // RULE_08
      else $error("pins not in port mode after reset");

   a_port_follows: assert property (@(posedge clock_i) disable iff (rst_i)
      !osc_sel_q |=> pins_o.oe_ri == $past(port_oe_i[0])
         && pins_o.oe_ro == $past(port_oe_i[1])) // RULE_09
      else $error("port drive not passed through");

   a_stop_halts: assert property (@(posedge clock_i) disable iff (rst_i)
      stop_insn_i |=> ##1 !int_osc_run_o && !xtal_en_o) // RULE_11
      else $error("stop did not halt clocks");

   a_cpu_clk_kept: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_osc && new_xstop && cpu_hs_sel_i && !xstop_q
         |=> !xstop_q) // RULE_12
      else $error("cpu clock source stopped");

   a_pin_sel_locked: assert property (@(posedge clock_i) disable iff (rst_i)
      wr_pin && hs_run |=> $stable(osc_sel_q) && $stable(ext_sel_q)) // RULE_07
      else $error("pin select changed while running");

   a_stab_bound: assert property (@(posedge clock_i) disable iff (rst_i)
      state_q == hcs_pkg::HCS_STABLE && !ext_sel_q
         |-> stab_q == hcs_pkg::STAB_TARGET) // RULE_06
      else $error("stable before wait elapsed");
endmodule

/* File: rtl/hcs_pin_mux.sv */
// high-speed clock pin routing between port, crystal and external clock
`timescale 1ns/1ps
module hcs_pin_mux (
   input wire logic clock_i,                     // system clock
   input wire logic rst_i,                       // sync reset, high
   input wire hcs_pkg::hcs_pin_mode_t mode_i,    // pin mode
   input wire logic ext_run_i,                   // external clock in use
   input wire logic [1:0] port_dout_i,           // port data out
   input wire logic [1:0] port_oe_i,             // port drive enable
   input wire logic [1:0] pin_i,                 // pin levels {ro,ri}
   output hcs_pkg::hcs_pin_drv_t pins_o,         // pin drive
   output logic [1:0] port_din_o,                // port data in
   output logic ext_clk_o                        // sampled external clock
);
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         pins_o <= '0;
      end
      else if (mode_i == hcs_pkg::HCS_PIN_PORT)
      begin
         pins_o.oe_ri <= port_oe_i[0]; // RULE_09
         pins_o.out_ri <= port_dout_i[0];
         pins_o.oe_ro <= port_oe_i[1];
         pins_o.out_ro <= port_dout_i[1];
      end
      else
      begin
         // resonator and clock source own the pins: no digital drive
         pins_o <= '0; // RULE_04 RULE_10
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         port_din_o <= 2'h0;
      end
      else
      begin
         port_din_o <= (mode_i == hcs_pkg::HCS_PIN_PORT) ? pin_i : 2'h0;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ext_clk_o <= 1'b0;
      end
      else
      begin
         ext_clk_o <= (mode_i == hcs_pkg::HCS_PIN_EXT) && ext_run_i
            && pin_i[1]; // RULE_10
      end
   end
endmodule

/* File: rtl/hcs_pkg.sv */
// package: register map, field layout, timing and types of the clock block
package hcs_pkg;
   localparam logic [15:0] TRIM_ADDR = 16'hFF30;
   localparam logic [15:0] PINCTL_ADDR = 16'hFF34;
   localparam logic [15:0] CLOCK_PIN_CONTROL_ADDR = 16'hFF38;
   localparam logic [15:0] STAT_ADDR = 16'hFF3C;
   localparam logic [4:0] TRIM_RST = 5'h10;
   localparam int TRIM_W = 5;
   localparam int PIN_OSC_SEL_BIT = 0;
   localparam int PIN_EXT_SEL_BIT = 1;
   localparam int OSC_XSTOP_BIT = 0;
   localparam int OSC_ISTOP_BIT = 1;
   localparam logic XSTOP_RST = 1'b1;
   localparam logic ISTOP_RST = 1'b0;
   localparam int CLK_PERIOD_NS = 4;
   localparam int STAB_STEP_NS = 1024;
   localparam int STAB_DIV_CYC = (STAB_STEP_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam logic [7:0] STAB_DIV_LAST = 8'(STAB_DIV_CYC - 1);
   localparam logic [7:0] STAB_TARGET = 8'h20;

   typedef enum logic [1:0] {
      HCS_OFF = 2'h0,
      HCS_START = 2'h1,
      HCS_STABLE = 2'h3,
      HCS_HALT = 2'h2
   } hcs_state_t;

   typedef enum logic [1:0] {
      HCS_PIN_PORT = 2'h0,
      HCS_PIN_XTAL = 2'h1,
      HCS_PIN_EXT = 2'h3
   } hcs_pin_mode_t;

   typedef struct packed {
      logic out_ro;
      logic oe_ro;
      logic out_ri;
      logic oe_ri;
   } hcs_pin_drv_t;

   // typical correction in hundredths of a percent
   function automatic logic signed [15:0] hcs_trim_typ(
      input logic [4:0] code);
      logic signed [15:0] t [32];
      t = '{-16'sd488, -16'sd462, -16'sd433, -16'sd403, -16'sd373,
            -16'sd343, -16'sd313, -16'sd283, -16'sd253, -16'sd222,
            -16'sd191, -16'sd160, -16'sd128, -16'sd96, -16'sd64,
            -16'sd32, 16'sd0, 16'sd32, 16'sd65, 16'sd98, 16'sd131,
            16'sd164, 16'sd198, 16'sd232, 16'sd266, 16'sd300, 16'sd334,
            16'sd369, 16'sd404, 16'sd439, 16'sd474, 16'sd510};
      return t[code];
   endfunction
endpackage

/* File: rtl/hcs_trim_map.sv */
// trim code to frequency correction lookup, registered
`timescale 1ns/1ps
module hcs_trim_map (
   input wire logic clock_i,               // system clock
   input wire logic rst_i,                 // sync reset, high
   input wire logic [4:0] code_i,          // trim code
   output logic signed [15:0] corr_o       // correction, 0.01 %
);
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         corr_o <= 16'sh0000;
      end
      else
      begin
         corr_o <= hcs_pkg::hcs_trim_typ(code_i); // RULE_02 RULE_03 RULE_13
      end
   end

   // table must never fold back
   a_trim_monotone: assert property (@(posedge clock_i) disable iff (rst_i)
      $past(code_i) < code_i |-> ##1 corr_o >= $past(corr_o)) // RULE_03
      else $error("trim correction reversed");
endmodule

/* File: testbench/hcs_clock_ctrl_test.sv */
// self-checking bench of the high-speed clock control block
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         error_cnt++; \
         $display("MISMATCH %0t got %0h exp %0h", $time, (g), (e)); \
      end \
   end
module hcs_clock_ctrl_test;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic [15:0] addr_i = 16'h0000;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic rd_chk = 1'b0;
   logic stop_insn_i = 1'b0;
   logic wake_i = 1'b0;
   logic cpu_hs_sel_i = 1'b0;
   logic [1:0] port_dout_i = 2'h0;
   logic [1:0] port_oe_i = 2'h0;
   logic ext_on = 1'b0;
   logic [1:0] drv_en = 2'h0;
   logic [1:0] drv_val = 2'h0;
   logic [1:0] pin_w;
   logic [7:0] rdata_o;
   hcs_pkg::hcs_pin_drv_t pins_o;
   logic [1:0] port_din_o;
   logic ext_clk_o;
   logic xtal_en_o;
   logic int_osc_run_o;
   logic hs_stable_o;
   logic [4:0] trim_code_o;
   logic signed [15:0] trim_corr_o;
   logic signed [15:0] prev;
   logic [7:0] exp_q [$];
   logic [7:0] rdv;
   logic chk_p = 1'b0;
   logic [1:0] a, b, c;
   logic ro_lvl;
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 51602;
   int n;

   hcs_clock_ctrl u_dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .stop_insn_i(stop_insn_i), .wake_i(wake_i),
      .cpu_hs_sel_i(cpu_hs_sel_i), .port_dout_i(port_dout_i),
      .port_oe_i(port_oe_i), .pin_i(pin_w), .pins_o(pins_o),
      .port_din_o(port_din_o), .ext_clk_o(ext_clk_o),
      .xtal_en_o(xtal_en_o), .int_osc_run_o(int_osc_run_o),
      .hs_stable_o(hs_stable_o), .trim_code_o(trim_code_o),
      .trim_corr_o(trim_corr_o));

   hcs_xtal_model u_xtal (.pins_i(pins_o), .xtal_en_i(xtal_en_o),
      .ext_on_i(ext_on), .drv_en_i(drv_en), .drv_val_i(drv_val),
      .pin_o(pin_w));

   initial
   begin
      forever #2 clock_i = ~clock_i;
   end

   task automatic finish_test;
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask

   task automatic wr(input logic [15:0] ad, input logic [7:0] d);
      @(posedge clock_i);
      wr_i <= 1'b1;
      addr_i <= ad;
      wdata_i <= d;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // ck low: value only captured in rdv, no note queued
   task automatic rd(input logic [15:0] ad, input logic [7:0] e,
      input logic ck);
      @(posedge clock_i);
      rd_i <= 1'b1;
      rd_chk <= ck;
      addr_i <= ad;
      if (ck)
         exp_q.push_back(e);
      @(posedge clock_i);
      rd_i <= 1'b0;
      rd_chk <= 1'b0;
      // read data stand only in this cycle
      #1;
      rdv = rdata_o;
   endtask

   always @(posedge clock_i)
   begin
      chk_p <= rd_i & rd_chk;
   end

   always @(negedge clock_i)
   begin
      if (chk_p)
         `CHK(rdata_o, exp_q.pop_front())
   end

   initial
   begin
      repeat (60000) @(posedge clock_i);
      error_cnt++;
      finish_test();
   end

   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      tick(1);
      `CHK(pins_o, 4'h0)
      `CHK(trim_code_o, 5'h10)
      `CHK(trim_corr_o, 16'h0000)
      rd(hcs_pkg::TRIM_ADDR, 8'h10, 1'b1);
      rd(hcs_pkg::PINCTL_ADDR, 8'h00, 1'b1);
      rd(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h01, 1'b1);
      rd(16'hFF40, 8'h00, 1'b1);
      prev = 16'hFDA8;
      for (int i = 0; i < 32; i++)
      begin
         wr(hcs_pkg::TRIM_ADDR, {3'($random(seed)), 5'(i)});
         tick(1);
         `CHK(trim_code_o, 5'(i))
         `CHK(trim_corr_o >= prev, 1'b1)
         if (i == 0)
            `CHK(trim_corr_o, 16'hFE18)
         if (i == 16)
            `CHK(trim_corr_o, 16'h0000)
         if (i == 31)
            `CHK(trim_corr_o, 16'h01FE)
         prev = trim_corr_o;
         rd(hcs_pkg::TRIM_ADDR, {3'h0, 5'(i)}, 1'b1);
      end
      wr(16'hFF40, 8'hFF);
      rd(hcs_pkg::TRIM_ADDR, 8'h1F, 1'b1);
      repeat (6)
      begin
         a = 2'($random(seed));
         b = 2'($random(seed));
         c = 2'($random(seed));
         @(posedge clock_i);
         port_dout_i <= a;
         port_oe_i <= b;
         drv_val <= c;
         drv_en <= 2'h3;
         tick(3);
         `CHK(pins_o, {a[1], b[1], a[0], b[0]})
         `CHK(port_din_o, (a & b) | (c & ~b))
      end
      @(posedge clock_i);
      drv_en <= 2'h0;
      port_oe_i <= 2'h0;
      wr(hcs_pkg::PINCTL_ADDR, 8'h01);
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h00);
      tick(2);
      `CHK(xtal_en_o, 1'b1)
      `CHK(pins_o, 4'h0)
      `CHK(port_din_o, 2'h0)
      rd(hcs_pkg::PINCTL_ADDR, 8'h01, 1'b1);
      rdv = 8'h00;
      n = 0;
      // wait on the status before trusting the crystal
      while (rdv !== 8'h20 && n < 60)
      begin
         tick(200);
         rd(hcs_pkg::STAT_ADDR, 8'h00, 1'b0);
         if (rdv !== 8'h20)
            `CHK(hs_stable_o, 1'b0)
         n++;
      end
      `CHK(rdv, 8'h20)
      tick(3);
      `CHK(hs_stable_o, 1'b1)
      `CHK(int_osc_run_o, 1'b1)
      @(posedge clock_i);
      cpu_hs_sel_i <= 1'b1;
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h01);
      tick(3);
      `CHK(xtal_en_o, 1'b1)
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h02);
      tick(3);
      `CHK(int_osc_run_o, 1'b0)
      `CHK(hs_stable_o, 1'b1)
      rd(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h02, 1'b1);
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h00);
      tick(3);
      `CHK(int_osc_run_o, 1'b1)
      @(posedge clock_i);
      stop_insn_i <= 1'b1;
      @(posedge clock_i);
      stop_insn_i <= 1'b0;
      tick(3);
      `CHK(xtal_en_o, 1'b0)
      `CHK(int_osc_run_o, 1'b0)
      `CHK(hs_stable_o, 1'b0)
      @(posedge clock_i);
      wake_i <= 1'b1;
      @(posedge clock_i);
      wake_i <= 1'b0;
      tick(4);
      `CHK(xtal_en_o, 1'b1)
      rd(hcs_pkg::STAT_ADDR, 8'h00, 1'b0);
      `CHK(rdv < 8'h02, 1'b1)
      @(posedge clock_i);
      cpu_hs_sel_i <= 1'b0;
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h01);
      tick(2);
      `CHK(xtal_en_o, 1'b0)
      wr(hcs_pkg::PINCTL_ADDR, 8'h03);
      @(posedge clock_i);
      ext_on <= 1'b1;
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h00);
      tick(3);
      `CHK(hs_stable_o, 1'b1)
      `CHK(xtal_en_o, 1'b0)
      `CHK(pins_o, 4'h0)
      rd(hcs_pkg::PINCTL_ADDR, 8'h03, 1'b1);
      repeat (20)
      begin
         @(posedge clock_i);
         ro_lvl = pin_w[1];
         #1;
         `CHK(ext_clk_o, ro_lvl)
      end
      wr(hcs_pkg::CLOCK_PIN_CONTROL_ADDR, 8'h01);
      wr(hcs_pkg::PINCTL_ADDR, 8'h00);
      @(posedge clock_i);
      ext_on <= 1'b0;
      port_oe_i <= 2'h3;
      port_dout_i <= 2'h2;
      tick(3);
      `CHK(pins_o, 4'hD)
      finish_test();
   end
endmodule

/* File: testbench/hcs_xtal_model.sv */
// resonator and external clock source seen at the two clock pins
`timescale 1ns/1ps
module hcs_xtal_model #(
   parameter int HALF_NS = 10,
   parameter int START_NS = 41
) (
   input wire hcs_pkg::hcs_pin_drv_t pins_i, // device pin drive
   input wire logic xtal_en_i,               // amplifier enabled
   input wire logic ext_on_i,                // external source fitted
   input wire logic [1:0] drv_en_i,          // board driver on {ro,ri}
   input wire logic [1:0] drv_val_i,         // board driver level
   output logic [1:0] pin_o                  // pin levels {ro,ri}
);
   logic osc = 1'b0;
   logic eclk = 1'b0;
   logic pat = 1'b0;
   // undriven pins wander, so a stale level never passes for data
   initial
   begin
      #1;
      forever #4 pat = ~pat;
   end
   // slow start: oscillation only after START_NS
   always
   begin
      wait (xtal_en_i === 1'b1);
      #(START_NS);
      while (xtal_en_i === 1'b1) #(HALF_NS) osc = ~osc;
   end
   // odd offset keeps edges away from the system clock edges
   always
   begin
      wait (ext_on_i === 1'b1);
      #1;
      while (ext_on_i === 1'b1) #(HALF_NS) eclk = ~eclk;
   end
   always_comb
   begin
      pin_o[0] = pins_i.oe_ri ? pins_i.out_ri : drv_en_i[0] ? drv_val_i[0]
         : xtal_en_i ? osc : pat;
      pin_o[1] = pins_i.oe_ro ? pins_i.out_ro : drv_en_i[1] ? drv_val_i[1]
         : ext_on_i ? eclk : xtal_en_i ? ~osc : ~pat;
   end
endmodule
